// ==== common/rst_seq_consts.vh ====
`ifndef RST_SEQ_CONSTS_VH
`define RST_SEQ_CONSTS_VH
// ==========================================
// Clock
`define CLK_PERIOD_NS 25
// ==========================================
// Times in their own units
`define SPIKE_REJECT_US 5
`define RESET_VALID_US 15
`define BLANK_MAX_MS 120
`define RELOAD_MAX_MS 10
// ==========================================
// Cycle counts derived from the times
`define SPIKE_REJECT_CYC ((`SPIKE_REJECT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_VALID_CYC ((`RESET_VALID_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_MAX_CYC ((`BLANK_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define RELOAD_MAX_CYC ((`RELOAD_MAX_MS * 1000000) / `CLK_PERIOD_NS)
// ==========================================
// Strap encoding
`define STRAP_TWO_SUPPLY 1'b1
`endif

// ==== src/reset_pulse_filter.v ====
`timescale 1ns/1ps
`include "rst_seq_consts.vh"
// ==========================================
// Qualifies the low pulse on the reset pin
module reset_pulse_filter #(
  parameter integer VALID_CYC = `RESET_VALID_CYC,
  parameter integer CNT_W = 10
) (
  input wire mclk_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire hw_reset_n_in,
  output reg pin_low_out,
  output reg reset_valid_out,
  output reg release_out
);
  reg [2:0] sync_r;
  reg [CNT_W-1:0] low_cnt_r;
  reg armed_r;
  wire agreed_low = ~sync_r[1] & ~sync_r[2];
  wire agreed_high = sync_r[1] & sync_r[2];

  always @(posedge mclk_in) begin
    if (reset_in) begin
      sync_r <= 3'h7;
      low_cnt_r <= {CNT_W{1'b0}};
      armed_r <= 1'b0;
      pin_low_out <= 1'b0;
      reset_valid_out <= 1'b0;
      release_out <= 1'b0;
    end else if (clk_en_in) begin
      sync_r <= {sync_r[1:0], hw_reset_n_in};
      release_out <= 1'b0;
      reset_valid_out <= 1'b0;
      if (agreed_low) begin
        pin_low_out <= 1'b1;
        if (low_cnt_r == VALID_CYC[CNT_W-1:0] - 1'b1) begin
          armed_r <= 1'b1;
          reset_valid_out <= 1'b1;
        end
        if (low_cnt_r != VALID_CYC[CNT_W-1:0])
          low_cnt_r <= low_cnt_r + 1'b1;
      end else if (agreed_high) begin
        pin_low_out <= 1'b0;
        low_cnt_r <= {CNT_W{1'b0}};
        if (armed_r)
          release_out <= 1'b1;
        armed_r <= 1'b0;
      end
    end
  end
endmodule

// ==== src/display_driver_reset_sequencer.v ====
`timescale 1ns/1ps
`include "rst_seq_consts.vh"
// How it works
// - A reset low pulse shorter than 5 us is a spike and starts no reset.
// - A low pulse of 601 clocks (15 us plus one clock) or more resets the device; the host must hold it that long.
// - Reset taken while awake runs a blanking span ending 120 ms plus five clocks after the rise; blank_out stays high until a wake command.
// - Reset taken while asleep keeps the panel blanked and restores defaults at once.
// - Every qualified pin reset reloads the nonvolatile store, finishing 10 ms plus five clocks after the rise; reset_in loads none.
// - Strap high selects two-supply mode with external power IC; low is reserved.
module display_driver_reset_sequencer #(
  parameter integer RELOAD_CYC = `RELOAD_MAX_CYC,
  parameter integer BLANK_CYC = `BLANK_MAX_CYC,
  parameter integer LOAD_WORDS = 4,
  parameter integer WORD_W = 8
) (
  input wire mclk_in,
  input wire reset_in,
  input wire clk_en_in,
  input wire hw_reset_n_in,
  input wire power_mode_strap_in,
  input wire cmd_valid_in,
  input wire [WORD_W-1:0] cmd_data_in,
  input wire wake_from_sleep_cmd_in,
  input wire sleep_in_cmd_in,
  input wire [WORD_W-1:0] store_data_in,
  output reg [1:0] store_addr_out,
  output reg [LOAD_WORDS*WORD_W-1:0] config_regs_out,
  output wire cmd_ready_out,
  output reg blank_out,
  output reg awake_out,
  output reg ready_out,
  output reg two_supply_mode_out,
  output reg strap_fault_out
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_HOLD = 3'h1;
  localparam [2:0] ST_RELOAD = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [2:0] ST_BLANK = 3'h4;
  localparam CNT_W = 23;

  wire reset_valid;
  wire release_pulse;
  wire load_we;
  wire cmd_take;
  wire cmd_write;
  wire [LOAD_WORDS*WORD_W-1:0] cfg_nxt;
  reg [2:0] state_r;
  reg [CNT_W-1:0] cnt_r;
  reg blank_run_r;
  reg [1:0] word_r;
  reg [2:0] strap_sync_r;
  reg [1:0] strap_fill_r;
  reg strap_taken_r;

  // ==========================================
  // Pin qualification
  reset_pulse_filter #(
    .VALID_CYC(`RESET_VALID_CYC),
    .CNT_W(10)
  ) u_filter (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .hw_reset_n_in(hw_reset_n_in),
    .pin_low_out(),
    .reset_valid_out(reset_valid),
    .release_out(release_pulse)
  );

  assign cmd_ready_out = ready_out;

  // ==========================================
  // Command acceptance
  // Taken only in idle and blanking, so a reload in progress is never
  // overwritten; a qualified reset in the same cycle wins over the command.
  assign cmd_take = ready_out && cmd_valid_in && !reset_valid &&
    ((state_r == ST_IDLE) || (state_r == ST_BLANK));
  assign cmd_write = cmd_take && !wake_from_sleep_cmd_in && !sleep_in_cmd_in;
  assign load_we = (state_r == ST_RELOAD);

  // ==========================================
  // Per-word next value of the internal registers
  // Reload and host writes share one rotating index; they never overlap
  // because commands are refused while the reload runs.
  genvar g;
  generate
    for (g = 0; g < LOAD_WORDS; g = g + 1) begin : g_word
      // Store word lands at its index
      assign cfg_nxt[g*WORD_W +: WORD_W] =
        reset_valid ? {WORD_W{1'b0}} :
        (load_we && (word_r == g)) ? store_data_in :
        (cmd_write && (word_r == g)) ? cmd_data_in :
        config_regs_out[g*WORD_W +: WORD_W];
    end
  endgenerate

  // ==========================================
  // Sequencer
  always @(posedge mclk_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      cnt_r <= {CNT_W{1'b0}};
      blank_run_r <= 1'b0;
      word_r <= 2'h0;
      store_addr_out <= 2'h0;
      config_regs_out <= {LOAD_WORDS*WORD_W{1'b0}};
      blank_out <= 1'b1;
      awake_out <= 1'b0;
      ready_out <= 1'b0;
    end else if (clk_en_in) begin
      config_regs_out <= cfg_nxt;
      // Sleep state follows the host commands
      if (cmd_take) begin
        if (wake_from_sleep_cmd_in) begin
          awake_out <= 1'b1;
          blank_out <= 1'b0;
        end else if (sleep_in_cmd_in) begin
          awake_out <= 1'b0;
          blank_out <= 1'b1;
        end else begin
          word_r <= word_r + 1'b1;
        end
      end
      case (state_r)
        ST_IDLE: begin
          cnt_r <= {CNT_W{1'b0}};
        end
        ST_HOLD: begin
          cnt_r <= {CNT_W{1'b0}};
          word_r <= 2'h0;
          store_addr_out <= 2'h0;
          if (release_pulse)
            state_r <= ST_RELOAD;
        end
        ST_RELOAD: begin
          word_r <= word_r + 1'b1;
          store_addr_out <= store_addr_out + 1'b1;
          cnt_r <= cnt_r + 1'b1;
          if (word_r == LOAD_WORDS[1:0] - 1'b1) begin
            word_r <= 2'h0;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Ready at the 10 ms mark
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= RELOAD_CYC[CNT_W-1:0] - 1'b1) begin
            ready_out <= 1'b1;
            state_r <= blank_run_r ? ST_BLANK : ST_IDLE;
          end
        end
        ST_BLANK: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= BLANK_CYC[CNT_W-1:0] - 1'b1) begin
            blank_run_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // A qualified pulse restarts the sequence from any state; shorter
      // dips never get here, so a spike cannot abort a reload or blanking.
      if (reset_valid) begin
        blank_run_r <= awake_out;
        blank_out <= 1'b1;
        awake_out <= 1'b0;
        ready_out <= 1'b0;
        state_r <= ST_HOLD;
      end
    end
  end

  // ==========================================
  // Strap, caught after reset release
  always @(posedge mclk_in) begin
    if (reset_in) begin
      strap_sync_r <= 3'h0;
      strap_fill_r <= 2'h0;
      strap_taken_r <= 1'b0;
      two_supply_mode_out <= 1'b0;
      strap_fault_out <= 1'b0;
    end else if (clk_en_in) begin
      strap_sync_r <= {strap_sync_r[1:0], power_mode_strap_in};
      // Reset contents of the chain are not pin samples; wait until it fills
      if (strap_fill_r != 2'h3)
        strap_fill_r <= strap_fill_r + 1'b1;
      if (!strap_taken_r && (strap_fill_r == 2'h3) &&
          (strap_sync_r[1] == strap_sync_r[2])) begin
        strap_taken_r <= 1'b1;
        two_supply_mode_out <= (strap_sync_r[2] == `STRAP_TWO_SUPPLY);
        strap_fault_out <= (strap_sync_r[2] != `STRAP_TWO_SUPPLY);
      end
    end
  end
endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
// ==========
// Host side of the reset pin
module host_model (
  input wire mclk_in,
  input wire go_in,
  input wire [15:0] low_cyc_in,
  output reg hw_reset_n_out
);
  integer n = 0;
  initial hw_reset_n_out = 1'b1;
  always @(posedge mclk_in) begin
    if (go_in)
      n <= low_cyc_in;
    else if (n != 0)
      n <= n - 1;
    hw_reset_n_out <= !go_in && n <= 1;
  end
endmodule

// ==== tb/display_driver_reset_sequencer_assertions.sv ====
`timescale 1ns/1ps
// ==========
// Port checks
module rst_seq_checker #(
  parameter integer RELOAD_CYC = 50
) (
  input wire mclk_in,
  input wire reset_in,
  input wire hw_reset_n_in,
  input wire power_mode_strap_in,
  input wire cmd_valid_in,
  input wire wake_from_sleep_cmd_in,
  input wire sleep_in_cmd_in,
  input wire blank_out,
  input wire awake_out,
  input wire ready_out,
  input wire two_supply_mode_out
);
  localparam int RL = RELOAD_CYC + 20;
  reg [10:0] low_r = 11'h000;
  // Saturates so a long power-on hold never wraps
  always @(posedge mclk_in)
    low_r <= hw_reset_n_in ? 11'h000 : low_r + (low_r != 11'h7FF);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_qual_rise;
    $past(low_r) > 11'd650 ##0 $rose(hw_reset_n_in);
  endsequence
  sequence s_cmd;
    cmd_valid_in && ready_out;
  endsequence
  property p_spike; $fell(ready_out) |-> low_r > 11'd200; endproperty
  a_spike: assert property (p_spike) else $error("ready fell on a spike");
  property p_valid; low_r == 11'd620 |-> !ready_out && blank_out; endproperty
  a_valid: assert property (p_valid) else $error("long pulse did not reset");
  property p_reload; s_qual_rise |-> ##[1:RL] ready_out; endproperty
  a_reload: assert property (p_reload) else $error("reload too slow");
  property p_blank; $fell(awake_out) |-> ##[0:2] blank_out; endproperty
  a_blank: assert property (p_blank) else $error("no blanking");
  property p_wake; s_cmd ##0 wake_from_sleep_cmd_in |-> ##[1:2] awake_out; endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");
  property p_sleep; s_cmd ##0 sleep_in_cmd_in |-> ##[1:2] !awake_out; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not taken");
  property p_ignore; cmd_valid_in && !ready_out && !awake_out |=> !awake_out; endproperty
  a_ignore: assert property (p_ignore) else $error("early command taken");
  property p_strap; $rose(ready_out) |-> two_supply_mode_out == power_mode_strap_in; endproperty
  a_strap: assert property (p_strap) else $error("mode not from strap");
endmodule
bind display_driver_reset_sequencer rst_seq_checker #(.RELOAD_CYC(RELOAD_CYC)) u_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .hw_reset_n_in(hw_reset_n_in),
  .power_mode_strap_in(power_mode_strap_in), .cmd_valid_in(cmd_valid_in),
  .wake_from_sleep_cmd_in(wake_from_sleep_cmd_in), .sleep_in_cmd_in(sleep_in_cmd_in),
  .blank_out(blank_out), .awake_out(awake_out), .ready_out(ready_out),
  .two_supply_mode_out(two_supply_mode_out));

// ==== tb/display_driver_reset_sequencer_bench.sv ====
`timescale 1ns/1ps
// ==========
// Reset sequencing bench
module display_driver_reset_sequencer_bench;
  reg mclk_in = 0, reset_in = 1, strap = 1, cv = 0, wk = 0, sl = 0, go = 0, mr = 0;
  reg [7:0] cd = 8'h00;
  reg [15:0] low = 16'h0000;
  reg [31:0] seed = 32'h19;
  reg [7:0] ex [0:3];
  wire pin, cr, blank, awake, rdy, two, flt;
  wire [1:0] sa;
  wire [31:0] cfg;
  integer errors = 0, total_checks = 0, i, k, idx;
  initial forever #12.5 mclk_in = !mclk_in;
  host_model HOST (.mclk_in(mclk_in), .go_in(go), .low_cyc_in(low), .hw_reset_n_out(pin));
  display_driver_reset_sequencer #(.RELOAD_CYC(50), .BLANK_CYC(100)) DUT (.mclk_in(mclk_in),
    .reset_in(reset_in), .clk_en_in(1'b1), .hw_reset_n_in(pin), .power_mode_strap_in(strap),
    .cmd_valid_in(cv), .cmd_data_in(cd), .wake_from_sleep_cmd_in(wk), .sleep_in_cmd_in(sl),
    .store_data_in({6'h2C, sa}), .store_addr_out(sa), .config_regs_out(cfg),
    .cmd_ready_out(cr), .blank_out(blank), .awake_out(awake), .ready_out(rdy),
    .two_supply_mode_out(two), .strap_fault_out(flt));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  endtask
  function [31:0] xs(input integer unused);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task pulse(input integer n);
    @(posedge mclk_in);
    go <= 1;
    low <= n;
    @(posedge mclk_in);
    go <= 0;
    repeat (n + 1) @(posedge mclk_in);
  endtask
  // Model: reload restores store words, index restarts
  task reload;
    for (i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge mclk_in);
    #1;
    for (k = 0; k < 4; k++) ex[k] = {6'h2C, k[1:0]};
    idx = 0;
    mr = 1;
    chk("ready", 1, rdy);
    chk("config", {ex[3], ex[2], ex[1], ex[0]}, cfg);
  endtask
  task cmd(input w, input s, input [7:0] d);
    @(posedge mclk_in);
    cv <= 1;
    wk <= w;
    sl <= s;
    cd <= d;
    @(posedge mclk_in);
    cv <= 0;
    if (mr && !w && !s) begin
      ex[idx] = d;
      idx = (idx + 1) % 4;
    end
    #1;
  endtask
  initial begin
    repeat (16) @(posedge mclk_in);
    reset_in <= 0;
    pulse(40000);
    cmd(0, 0, 8'h5A);
    cmd(1, 0, 8'h00);
    reload;
    chk("awake", 0, awake);
    chk("mode", 1, two);
    $display("test 1 done");
    for (k = 0; k < 5; k++)
      cmd(0, 0, xs(0));
    chk("config", {ex[3], ex[2], ex[1], ex[0]}, cfg);
    // this reset came while asleep, so no blanking span runs; wake still waits 110 cycles
    repeat (110) @(posedge mclk_in);
    // wake follows the complete init words
    cmd(1, 0, 8'h00);
    chk("awake", 1, awake);
    chk("blank", 0, blank);
    $display("test 2 done");
    pulse(150);
    chk("ready", 1, {rdy & cr & awake});
    pulse(700);
    chk("ready", 0, rdy);
    chk("blank", 1, blank);
    reload;
    chk("awake", 0, awake);
    repeat (110) @(posedge mclk_in);
    chk("blank", 1, blank);
    $display("test 3 done");
    cmd(1, 0, 8'h00);
    chk("awake", 1, awake);
    cmd(0, 1, 8'h00);
    chk("awake", 0, awake);
    chk("blank", 1, blank);
    pulse(700);
    reload;
    repeat (200) @(posedge mclk_in);
    chk("blank", 1, blank);
    $display("test 4 done");
    reset_in <= 1;
    strap <= 0;
    repeat (4) @(posedge mclk_in);
    reset_in <= 0;
    repeat (8) @(posedge mclk_in);
    chk("fault", 2'b10, {flt, two});
    $display("test 5 done");
    wrap_up;
  end
  initial begin
    #(80000 * 25);
    errors++;
    wrap_up;
  end
endmodule
